// ===== common/mb_link_defs.vh
// Constants shared by the RTU slave link design files
`ifndef MB_LINK_DEFS_VH
`define MB_LINK_DEFS_VH
// ==========================================================
// Clock and line rates
`define CLK_HZ_DEFAULT   125000000
`define BAUD_1200        1200
`define BAUD_2400        2400
`define BAUD_4800        4800
`define BAUD_9600        9600
`define BAUD_19200       19200
`define BAUD_38400       38400
`define BAUD_57600       57600
`define BAUD_SEL_RESET   3'h3
// ==========================================================
// Character and frame timing
`define CHAR_BITS        11
`define GAP_CHARS_X2     7
`define GAP_HALF_BITS    7'h4d
`define MIN_FRAME        7'h04
`define CRC_BYTES        7'h02
// ==========================================================
// Parity modes
`define PAR_NONE         2'h0
`define PAR_ODD          2'h1
`define PAR_EVEN         2'h2
// ==========================================================
// Protocol values
`define FC_READ          8'h03
`define FC_WRITE         8'h06
`define FC_LOOP          8'h08
`define MAX_READ_WORDS   8'h14
`define MAX_STATION      8'hf7
`define BROADCAST_ADDR   8'h00
`define STATION_RESET    8'h01
`define CRC_INIT         16'hffff
`define CRC_POLY         16'ha001
`define CRC_RESIDUE      16'h0000
// ==========================================================
// Register map
`define A_CTRL           8'h00
`define A_STATUS         8'h01
`define A_STATION        8'h02
`define A_RX_LEN         8'h03
`define A_TX_LEN         8'h04
`define A_RX_CRC_LO      8'h05
`define A_RX_CRC_HI      8'h06
`define WIN_RX_BUF       2'h1
`define WIN_TX_BUF       2'h2
`define BUF_DEPTH        64
// ==========================================================
// Control and status fields
`define CTRL_BAUD_LSB    0
`define CTRL_PAR_LSB     3
`define ST_FRAME_READY   0
`define ST_CRC_ERR       1
`define ST_PARITY_ERR    2
`define ST_FRAMING_ERR   3
`define ST_OVERRUN       4
`define ST_FUNC_ERR      5
`define ST_TX_REFUSED    6
`define ST_BROADCAST     7
`define TXL_BUSY         7
`endif

// ===== verilog/crc16_unit.v
// Byte-wide reflected CRC-16 accumulator
`timescale 1ns/100ps
`include "mb_link_defs.vh"
module crc16_unit (
  input  wire        clk,
  input  wire        rst,
  input  wire        init,
  input  wire        en,
  input  wire [7:0]  data,
  output reg  [15:0] crc
);
  wire [15:0] stage [0:8];

  // Byte enters the low bits before the shifts
  assign stage[0] = crc ^ {8'h00, data};

  // ==========================================================
  // Eight shift steps, poly applied when a one falls out
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_shift
      assign stage[i+1] = stage[i][0] ? ((stage[i] >> 1) ^ `CRC_POLY) : (stage[i] >> 1);
    end
  endgenerate

  // ==========================================================
  // Init wins over update so a frame never inherits old state
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      crc <= `CRC_INIT;
    end else if (init) begin
      crc <= `CRC_INIT;
    end else if (en) begin
      crc <= stage[8];
    end
  end
endmodule

// ===== verilog/char_tx.v
// Serialiser for one asynchronous character
`timescale 1ns/100ps
`include "mb_link_defs.vh"
module char_tx (
  input  wire        clk,
  input  wire        rst,
  input  wire        start,
  input  wire [7:0]  data,
  input  wire [1:0]  parity_mode,
  input  wire [16:0] bit_cycles,
  output reg         txd,
  output reg         busy
);
  reg  [9:0]  sh;
  reg  [3:0]  nbits;
  reg  [16:0] cnt;
  reg         par_bit;

  // Parity slot; without parity it carries a second stop bit
  always @* begin
    case (parity_mode)
      `PAR_ODD:  par_bit = ~^data;
      `PAR_EVEN: par_bit = ^data;
      default:   par_bit = 1'b1;
    endcase
  end

  // ==========================================================
  // Start bit goes out at once, then ten more slots LSB first
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      txd   <= 1'b1;
      busy  <= 1'b0;
      sh    <= 10'h3ff;
      nbits <= 4'h0;
      cnt   <= 17'h00000;
    end else if (!busy) begin
      if (start) begin
        txd   <= 1'b0;
        sh    <= {1'b1, par_bit, data};
        nbits <= 4'ha;
        cnt   <= bit_cycles - 17'h00001;
        busy  <= 1'b1;
      end
    end else if (cnt != 17'h00000) begin
      cnt <= cnt - 17'h00001;
    end else if (nbits == 4'h0) begin
      busy <= 1'b0;
    end else begin
      txd   <= sh[0];
      sh    <= {1'b1, sh[9:1]};
      nbits <= nbits - 4'h1;
      cnt   <= bit_cycles - 17'h00001;
    end
  end
endmodule

// ===== verilog/rtu_slave_link.v
// RTU slave link: character receiver, frame delimiting, checking and reply sender
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`include "mb_link_defs.vh"
// Functional notes
// - Eight data bits, one stop bit
// - Seven selectable bit rates, 1200 to 57600
// - Parity odd, even or none
// - Binary RTU framing only, no ASCII
// - Frame starts after 3.5 character silence
// - 3.5 character silence ends a frame
// - Address, function, data, then check word
// - Station address accepts 0 through 247
// - Address zero is broadcast to all
// - Never reply to a broadcast request
// - Codes 03H read, 06H write, 08H loop
// - Parity bit makes ones count odd/even
// - No parity: extra stop bit sent instead
// - Sender appends 16-bit CRC to frame
// - Receiver flags CRC mismatch as error
// - CRC register starts at all ones
// - Only the data bits feed CRC
// - XOR byte, eight conditional shift steps
// - Master initiates; addressed slave replies
// - Read asks at most twenty words
module rtu_slave_link #(
  parameter CLK_HZ = `CLK_HZ_DEFAULT
) (
  input  wire       clk,
  input  wire       rst,
  input  wire [7:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  input  wire       rxd,
  output wire       txd,
  output reg        tx_enable
);
  // ==========================================================
  // Bit periods, derived from the clock rate
  localparam [31:0] BIT_1200  = CLK_HZ / `BAUD_1200;
  localparam [31:0] BIT_2400  = CLK_HZ / `BAUD_2400;
  localparam [31:0] BIT_4800  = CLK_HZ / `BAUD_4800;
  localparam [31:0] BIT_9600  = CLK_HZ / `BAUD_9600;
  localparam [31:0] BIT_19200 = CLK_HZ / `BAUD_19200;
  localparam [31:0] BIT_38400 = CLK_HZ / `BAUD_38400;
  localparam [31:0] BIT_57600 = CLK_HZ / `BAUD_57600;
  localparam [31:0] DEPTH_W   = `BUF_DEPTH;

  localparam [2:0] R_IDLE  = 3'h0;
  localparam [2:0] R_START = 3'h1;
  localparam [2:0] R_DATA  = 3'h2;
  localparam [2:0] R_PAR   = 3'h3;
  localparam [2:0] R_STOP  = 3'h4;

  localparam [2:0] T_IDLE = 3'h0;
  localparam [2:0] T_GAP  = 3'h1;
  localparam [2:0] T_BYTE = 3'h2;
  localparam [2:0] T_WAIT = 3'h3;
  localparam [2:0] T_CRCL = 3'h4;
  localparam [2:0] T_CRCH = 3'h5;

  reg  [7:0]  ctrl;
  reg  [7:0]  station;
  reg  [7:0]  status;
  reg  [7:0]  next_status;
  reg  [7:0]  st_set;
  reg  [7:0]  rx_mem [0:`BUF_DEPTH-1];
  reg  [7:0]  tx_mem [0:`BUF_DEPTH-1];
  reg  [16:0] bit_cycles;
  wire [1:0]  parity_mode = ctrl[`CTRL_PAR_LSB+1:`CTRL_PAR_LSB];
  wire [16:0] half_cycles = {1'b0, bit_cycles[16:1]};

  reg         rx_s1;
  reg         rx_s2;
  reg         rx_prev;
  reg  [2:0]  r_state;
  reg  [16:0] r_cnt;
  reg  [2:0]  r_bits;
  reg  [7:0]  r_sh;
  reg         par_bad;
  reg         byte_valid;
  reg  [16:0] hb_cnt;
  reg  [6:0]  idle_half;
  reg         gap_ok;
  reg         in_frame;
  reg  [6:0]  fill;
  reg  [6:0]  rx_len;
  reg         frame_end;
  wire [15:0] rx_crc;
  reg  [15:0] rx_crc_hold;

  reg  [2:0]  t_state;
  reg  [6:0]  t_len;
  reg  [6:0]  t_idx;
  reg         t_src;
  reg         t_crc_done;
  reg         t_init;
  reg  [7:0]  tx_byte;
  wire        tx_busy;
  wire [15:0] tx_crc;
  wire        tx_start = (t_state == T_BYTE) || (t_state == T_CRCL) || (t_state == T_CRCH);
  wire        line_quiet = (idle_half == `GAP_HALF_BITS);

  // Frame verdict inputs; the buffer holds address first, function second
  wire        is_bcast  = (rx_mem[0] == `BROADCAST_ADDR);
  wire        is_mine   = is_bcast || (rx_mem[0] == station);
  wire        len_ok    = (fill >= `MIN_FRAME) && (fill <= `BUF_DEPTH);
  wire        crc_ok    = (rx_crc == `CRC_RESIDUE);
  wire [7:0]  fc        = rx_mem[1];
  wire        qty_ok    = (rx_mem[4] == 8'h00) && (rx_mem[5] != 8'h00) && (rx_mem[5] <= `MAX_READ_WORDS);
  wire        fc_ok     = ((fc == `FC_READ) && qty_ok) || (fc == `FC_WRITE) || (fc == `FC_LOOP);
  wire        good      = frame_end && len_ok && crc_ok && is_mine;
  wire        echo_go   = good && fc_ok && (fc == `FC_LOOP) && !is_bcast && (t_state == T_IDLE);
  wire        sw_go     = wr && (addr == `A_TX_LEN);

  // ==========================================================
  // Bit period per selected rate; unused codes fall back to 9600
  always @* begin
    case (ctrl[`CTRL_BAUD_LSB+2:`CTRL_BAUD_LSB])
      3'h0:    bit_cycles = BIT_1200[16:0];
      3'h1:    bit_cycles = BIT_2400[16:0];
      3'h2:    bit_cycles = BIT_4800[16:0];
      3'h3:    bit_cycles = BIT_9600[16:0];
      3'h4:    bit_cycles = BIT_19200[16:0];
      3'h5:    bit_cycles = BIT_38400[16:0];
      3'h6:    bit_cycles = BIT_57600[16:0];
      default: bit_cycles = BIT_9600[16:0];
    endcase
  end

  // ==========================================================
  // Line synchroniser; the receiver looks at the second stage and its delayed copy
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_s1   <= 1'b1;
      rx_s2   <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_s1   <= rxd;
      rx_s2   <= rx_s1;
      rx_prev <= rx_s2;
    end
  end

  // ==========================================================
  // Character receiver, samples at mid-bit
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      r_state    <= R_IDLE;
      r_cnt      <= 17'h00000;
      r_bits     <= 3'h0;
      r_sh       <= 8'h00;
      par_bad    <= 1'b0;
      byte_valid <= 1'b0;
    end else begin
      byte_valid <= 1'b0;
      if (r_state != R_IDLE && r_cnt != 17'h00000) begin
        r_cnt <= r_cnt - 17'h00001;
      end else begin
        case (r_state)
          R_IDLE: begin
            if (rx_prev && !rx_s2) begin
              r_cnt   <= half_cycles - 17'h00001;
              par_bad <= 1'b0;
              r_state <= R_START;
            end
          end
          R_START: begin
            // A start bit that is gone at mid-bit was a glitch
            r_cnt   <= bit_cycles - 17'h00001;
            r_bits  <= 3'h0;
            r_state <= rx_s2 ? R_IDLE : R_DATA;
          end
          R_DATA: begin
            r_sh   <= {rx_s2, r_sh[7:1]};
            r_cnt  <= bit_cycles - 17'h00001;
            r_bits <= r_bits + 3'h1;
            if (r_bits == 3'h7) begin
              r_state <= (parity_mode == `PAR_NONE) ? R_STOP : R_PAR;
            end
          end
          R_PAR: begin
            par_bad <= (parity_mode == `PAR_ODD) ? (rx_s2 == ^r_sh) : (rx_s2 != ^r_sh);
            r_cnt   <= bit_cycles - 17'h00001;
            r_state <= R_STOP;
          end
          R_STOP: begin
            // Only the first stop bit is checked; a second one just reads as idle
            byte_valid <= 1'b1;
            r_state    <= R_IDLE;
          end
          default: r_state <= R_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // Silence timer in half-bit units, restarted by any line activity
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hb_cnt    <= 17'h00000;
      idle_half <= 7'h00;
    end else if (r_state != R_IDLE || !rx_s2 || tx_busy) begin
      hb_cnt    <= 17'h00000;
      idle_half <= 7'h00;
    end else if (hb_cnt + 17'h00001 >= half_cycles) begin
      hb_cnt <= 17'h00000;
      if (!line_quiet) begin
        idle_half <= idle_half + 7'h01;
      end
    end else begin
      hb_cnt <= hb_cnt + 17'h00001;
    end
  end

  // ==========================================================
  // Frame assembly; a byte is only taken inside a frame or after full silence
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_ok    <= 1'b0;
      in_frame  <= 1'b0;
      fill      <= 7'h00;
      frame_end <= 1'b0;
    end else begin
      frame_end <= 1'b0;
      if (byte_valid && (in_frame || gap_ok)) begin
        in_frame <= 1'b1;
        gap_ok   <= 1'b0;
        if (fill < `BUF_DEPTH) begin
          rx_mem[fill[5:0]] <= r_sh;
        end
        if (fill <= `BUF_DEPTH) begin
          fill <= fill + 7'h01;
        end
      end else if (byte_valid) begin
        gap_ok <= 1'b0;
      end else if (line_quiet) begin
        gap_ok <= 1'b1;
        if (in_frame) begin
          in_frame  <= 1'b0;
          frame_end <= 1'b1;
        end
      end
      if (frame_end) begin
        fill <= 7'h00;
      end
    end
  end

  // Receive checker starts fresh once the line has been quiet
  crc16_unit rx_crc_unit (
    .clk  (clk),
    .rst  (rst),
    .init (line_quiet && !in_frame),
    .en   (byte_valid && (in_frame || gap_ok)),
    .data (r_sh),
    .crc  (rx_crc)
  );

  // ==========================================================
  // Event collection; a set in the same cycle beats a software clear
  always @* begin
    st_set = 8'h00;
    st_set[`ST_PARITY_ERR]  = byte_valid && par_bad && (parity_mode != `PAR_NONE);
    st_set[`ST_FRAMING_ERR] = byte_valid && !rx_s2;
    st_set[`ST_OVERRUN]     = frame_end && (fill > `BUF_DEPTH);
    st_set[`ST_CRC_ERR]     = frame_end && len_ok && !crc_ok;
    st_set[`ST_FRAME_READY] = good;
    st_set[`ST_FUNC_ERR]    = good && !fc_ok;
    st_set[`ST_TX_REFUSED]  = sw_go && ((t_state != T_IDLE) || status[`ST_BROADCAST]);
    next_status = status;
    if (wr && addr == `A_STATUS) begin
      next_status = status & ~wdata;
    end
    next_status = next_status | st_set;
    if (good) begin
      next_status[`ST_BROADCAST] = is_bcast;
    end
  end

  // ==========================================================
  // Software registers; out-of-range station values are ignored
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl        <= {5'h00, `BAUD_SEL_RESET};
      station     <= `STATION_RESET;
      status      <= 8'h00;
      rx_len      <= 7'h00;
      rx_crc_hold <= 16'h0000;
    end else begin
      status <= next_status;
      if (wr && addr == `A_CTRL) begin
        ctrl <= wdata;
      end
      if (wr && addr == `A_STATION && wdata <= `MAX_STATION) begin
        station <= wdata;
      end
      if (good) begin
        rx_len      <= fill;
        rx_crc_hold <= {rx_mem[fill[5:0] - 6'h01], rx_mem[fill[5:0] - 6'h02]};
      end
    end
  end

  // Reply staging buffer, written by software
  always @(posedge clk) begin
    if (wr && addr[7:6] == `WIN_TX_BUF) begin
      tx_mem[addr[5:0]] <= wdata;
    end
  end

  // ==========================================================
  // Read port; data appear the cycle after the strobe
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      if (addr[7:6] == `WIN_RX_BUF) begin
        rdata <= rx_mem[addr[5:0]];
      end else begin
        case (addr)
          `A_CTRL:      rdata <= ctrl;
          `A_STATUS:    rdata <= status;
          `A_STATION:   rdata <= station;
          `A_RX_LEN:    rdata <= {1'b0, rx_len};
          `A_TX_LEN:    rdata <= {(t_state != T_IDLE), t_len};
          `A_RX_CRC_LO: rdata <= rx_crc_hold[7:0];
          `A_RX_CRC_HI: rdata <= rx_crc_hold[15:8];
          default:      rdata <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================
  // Byte offered to the serialiser in each sending state
  always @* begin
    case (t_state)
      T_CRCL:  tx_byte = tx_crc[7:0];
      T_CRCH:  tx_byte = tx_crc[15:8];
      default: tx_byte = t_src ? rx_mem[t_idx[5:0]] : tx_mem[t_idx[5:0]];
    endcase
  end

  // ==========================================================
  // Reply sequencer: gap, body bytes, then the check word
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      t_state    <= T_IDLE;
      t_len      <= 7'h00;
      t_idx      <= 7'h00;
      t_src      <= 1'b0;
      t_crc_done <= 1'b0;
      t_init     <= 1'b0;
      tx_enable  <= 1'b0;
    end else begin
      t_init    <= 1'b0;
      tx_enable <= (t_state != T_IDLE) && (t_state != T_GAP);
      case (t_state)
        T_IDLE: begin
          t_idx      <= 7'h00;
          t_crc_done <= 1'b0;
          if (echo_go) begin
            t_src   <= 1'b1;
            t_len   <= fill - `CRC_BYTES;
            t_init  <= 1'b1;
            t_state <= T_GAP;
          end else if (sw_go && !status[`ST_BROADCAST] && wdata[6:0] != 7'h00) begin
            t_src   <= 1'b0;
            t_len   <= (wdata[6:0] > DEPTH_W[6:0]) ? DEPTH_W[6:0] : wdata[6:0];
            t_init  <= 1'b1;
            t_state <= T_GAP;
          end
        end
        T_GAP: begin
          if (line_quiet) begin
            t_state <= T_BYTE;
          end
        end
        T_BYTE: begin
          t_idx   <= t_idx + 7'h01;
          t_state <= T_WAIT;
        end
        T_CRCL: begin
          t_state <= T_WAIT;
        end
        T_CRCH: begin
          t_crc_done <= 1'b1;
          t_state    <= T_WAIT;
        end
        T_WAIT: begin
          if (!tx_busy) begin
            if (t_idx < t_len) begin
              t_state <= T_BYTE;
            end else if (t_crc_done) begin
              t_state <= T_IDLE;
            end else if (t_idx == t_len) begin
              t_idx   <= t_idx + 7'h01;
              t_state <= T_CRCL;
            end else begin
              t_state <= T_CRCH;
            end
          end
        end
        default: t_state <= T_IDLE;
      endcase
    end
  end

  // Reply check word covers body bytes only
  crc16_unit tx_crc_unit (
    .clk  (clk),
    .rst  (rst),
    .init (t_init),
    .en   (t_state == T_BYTE),
    .data (tx_byte),
    .crc  (tx_crc)
  );

  char_tx u_char_tx (
    .clk         (clk),
    .rst         (rst),
    .start       (tx_start),
    .data        (tx_byte),
    .parity_mode (parity_mode),
    .bit_cycles  (bit_cycles),
    .txd         (txd),
    .busy        (tx_busy)
  );
endmodule

// ===== dv/rtu_link_chk.sv
// Port checker for the RTU slave link
`timescale 1ns/100ps
`include "mb_link_defs.vh"
module rtu_link_chk #(
  parameter CLK_HZ = 125000000
) (
  input wire       clk,
  input wire       rst,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata,
  input wire       rxd,
  input wire       txd,
  input wire       tx_enable
);
  // ==========================================================
  // Helper logic
  localparam int GAP = (CLK_HZ / 57600) * 77 / 2;
  int quiet;
  // Quiet cycles on the receive line, saturating at the shortest legal gap
  always @(posedge clk or posedge rst) begin
    if (rst)
      quiet <= 0;
    else if (!rxd)
      quiet <= 0;
    else if (quiet < GAP)
      quiet <= quiet + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence station_wr;
    wr && addr == `A_STATION && wdata <= `MAX_STATION;
  endsequence
  sequence station_rd;
    rd && addr == `A_STATION;
  endsequence
  // ==========================================================
  // Assertions
  chk_reset_idle:
    assert property (disable iff (1'b0) rst |-> txd && !tx_enable) else $error("line not idle in reset");
  chk_station_back:
    assert property (station_wr ##2 station_rd |=> rdata == $past(wdata, 3)) else $error("station readback wrong");
  chk_unmapped_zero:
    assert property (rd && addr == 8'h10 |=> rdata == 8'h00) else $error("unmapped read not zero");
  chk_rdata_hold:
    assert property (!rd |=> $stable(rdata)) else $error("read data moved without a read");
  chk_idle_high:
    assert property (!tx_enable |-> txd) else $error("txd low while driver off");
  chk_start_bit:
    assert property ($fell(txd) |-> !txd [*8]) else $error("start bit too short");
  chk_enable_lead:
    assert property ($rose(tx_enable) |-> ##[0:40] !txd) else $error("no start bit after enable");
  chk_enable_tail:
    assert property ($fell(tx_enable) |-> $past(txd, 1) && $past(txd, 8)) else $error("enable dropped in a bit");
  chk_reply_gap:
    assert property ($rose(tx_enable) |-> quiet == GAP) else $error("reply without silence");
endmodule

// ===== dv/mb_master.sv
// Bus master model standing on the far side of the RS-485 line
`timescale 1ns/100ps
module mb_master #(
  parameter BIT = 20
) (
  input  wire clk,
  input  wire txd,
  input  wire tx_enable,
  output reg  rxd
);
  logic [1:0] par_mode;
  logic [7:0] got[$];
  int         n_err;
  // Line idles high between characters
  initial begin
    rxd = 1'b1;
    par_mode = 2'h0;
    n_err = 0;
  end
  // Parity bit giving an odd or even ones count
  function automatic logic par_of(input [7:0] b);
    par_of = (par_mode == 2'h1) ? ~^b : ^b;
  endfunction
  // Start, data LSB first, parity or extra stop, stop
  task automatic send_byte(input [7:0] b);
    logic [10:0] sh;
    sh = {1'b1, (par_mode == 2'h0) ? 1'b1 : par_of(b), b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= sh[i];
      repeat (BIT) @(posedge clk);
    end
  endtask
  // Reply receiver sampling mid-bit; the extra stop slot is checked too
  initial begin
    logic [7:0] b;
    forever begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge clk);
      if (txd !== 1'b0) n_err++;
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clk);
        b[i] = txd;
      end
      repeat (BIT) @(posedge clk);
      if (txd !== ((par_mode == 2'h0) ? 1'b1 : par_of(b))) n_err++;
      repeat (BIT) @(posedge clk);
      if (txd !== 1'b1 || tx_enable !== 1'b1) n_err++;
      got.push_back(b);
    end
  end
endmodule

// ===== dv/modbus_rtu_slave_link_bench.sv
// Self-checking bench for the RTU slave link
`timescale 1ns/100ps
`include "mb_link_defs.vh"
module modbus_rtu_slave_link_bench;
  // Slow clock setting so 57600 baud is 20 clocks a bit
  localparam int HZ = 1152000;
  localparam int BIT = 20;
  logic       clk;
  logic       rst;
  logic       wr;
  logic       rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  wire  [7:0] rdata;
  wire        rxd;
  wire        txd;
  wire        tx_enable;
  int         n_fail;
  int         checks;
  int         cyc;
  logic [7:0] frm[$];
  logic [15:0] c;
  rtu_slave_link #(.CLK_HZ(HZ)) i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rxd(rxd), .txd(txd), .tx_enable(tx_enable));
  mb_master #(.BIT(BIT)) i_master (.clk(clk), .txd(txd), .tx_enable(tx_enable), .rxd(rxd));
  // ==========================================================
  // Clock and cycle ceiling
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // A lost reply must not hang the run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      n_fail++;
      wrap_up();
    end
  end
  // ==========================================================
  // Tasks
  task automatic check(input string what, input [15:0] seen, input [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Register write; an idle cycle follows so strobes never change twice in a step
  task automatic wreg(input [7:0] a, input [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // Register read; data is taken in the cycle after the strobe and holds until the next read
  task automatic rchk(input [7:0] a, input [7:0] m, input [7:0] e, input string what);
    logic [7:0] d;
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
    check(what, {8'h00, d & m}, {8'h00, e});
  endtask
  function automatic logic [15:0] crc16(input int n);
    logic [15:0] r;
    r = 16'hffff;
    for (int i = 0; i < n; i++) begin
      r = r ^ {8'h00, frm[i]};
      for (int k = 0; k < 8; k++) r = r[0] ? (r >> 1) ^ 16'ha001 : r >> 1;
    end
    crc16 = r;
  endfunction
  // Wait for a reply of nrep bytes, or watch for silence when none is due
  task automatic expect_reply(input int nrep);
    int lim;
    lim = (nrep > 0) ? 4000 : 2500;
    for (int i = 0; i < lim && i_master.got.size() < nrep + (nrep == 0); i++) @(posedge clk);
    check("reply length", 16'(i_master.got.size()), 16'(nrep));
    for (int i = 0; i < nrep; i++) check("reply byte", {8'h00, i_master.got[i]}, {8'h00, frm[i]});
  endtask
  // One request after a full silence, then reply and status
  task automatic frame(input [7:0] st, input [7:0] fc, input [15:0] w, input bit bad, input [7:0] m,
    input [7:0] e, input int nrep);
    frm = '{st, fc, 8'h21, 8'h00, w[15:8], w[7:0]};
    c = crc16(6);
    frm.push_back(c[7:0] ^ {7'h00, bad});
    frm.push_back(c[15:8]);
    wreg(`A_STATUS, 8'hff);
    i_master.got.delete();
    repeat (BIT * 40) @(posedge clk);
    foreach (frm[i]) i_master.send_byte(frm[i]);
    expect_reply(nrep);
    rchk(`A_STATUS, m, e, "status");
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    cyc = 0;
    n_fail = 0;
    checks = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk(`A_CTRL, 8'hff, 8'h03, "ctrl reset");
    rchk(`A_STATION, 8'hff, 8'h01, "station reset");
    rchk(8'h10, 8'hff, 8'h00, "unmapped");
    wreg(`A_STATION, 8'hf7);
    rchk(`A_STATION, 8'hff, 8'hf7, "station max");
    wreg(`A_STATION, 8'hf8);
    rchk(`A_STATION, 8'hff, 8'hf7, "station over");
    wreg(`A_STATION, 8'h05);
    // Echo test in each parity mode at the fastest rate
    for (int m = 0; m < 3; m++) begin
      wreg(`A_CTRL, {3'h0, 2'(m), 3'h6});
      i_master.par_mode = 2'(m);
      if (m == 0) repeat (5000) @(posedge clk);
      frame(8'h05, `FC_LOOP, 16'h1388, 1'b0, 8'hff, 8'h01, 8);
    end
    rchk(`A_RX_LEN, 8'hff, 8'h08, "rx length");
    rchk(`A_RX_CRC_LO, 8'hff, frm[6], "crc low");
    rchk(`A_RX_CRC_HI, 8'hff, frm[7], "crc high");
    rchk(8'h41, 8'hff, `FC_LOOP, "rx buffer fc");
    frame(8'h00, `FC_LOOP, 16'h1388, 1'b0, 8'h81, 8'h81, 0);
    wreg(`A_TX_LEN, 8'h04);
    expect_reply(0);
    rchk(`A_STATUS, 8'h40, 8'h40, "tx refused");
    frame(8'h05, `FC_LOOP, 16'h1388, 1'b1, 8'h02, 8'h02, 0);
    frame(8'h07, `FC_LOOP, 16'h1388, 1'b0, 8'h3f, 8'h00, 0);
    frame(8'h05, `FC_WRITE, 16'h1388, 1'b0, 8'h21, 8'h01, 0);
    frame(8'h05, 8'h11, 16'h0003, 1'b0, 8'h20, 8'h20, 0);
    frame(8'h05, `FC_READ, 16'h0015, 1'b0, 8'h20, 8'h20, 0);
    frame(8'h05, `FC_READ, 16'h0014, 1'b0, 8'h21, 8'h01, 0);
    // Software-built read reply; hardware appends the check word
    frm = '{8'h05, 8'h03, 8'h02, 8'h12, 8'h34};
    foreach (frm[i]) wreg(8'(8'h80 + i), frm[i]);
    c = crc16(5);
    frm.push_back(c[7:0]);
    frm.push_back(c[15:8]);
    i_master.got.delete();
    wreg(`A_TX_LEN, 8'h05);
    expect_reply(7);
    check("wire errors", 16'(i_master.n_err), 16'h0000);
    wrap_up();
  end
endmodule
bind rtu_slave_link rtu_link_chk #(.CLK_HZ(CLK_HZ)) i_chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .txd(txd), .tx_enable(tx_enable));
